// file: vpc_channel_control.v
// channel control for a four-channel video port
// assumes link pins are asynchronous, datapath signals share clk
// Function
// RULE_01: hardware reset only, registers to defaults
// RULE_02: host enables, sizes, then emulation setup
// RULE_03: four frame events and one error event
// RULE_04: capture error: overflow, length, code bit
// RULE_05: display error only on buffer overflow
// RULE_06: each event signalled once, never reissued
// RULE_07: frame event after last bus transfer
// RULE_08: YC event at first/bottom line end
// RULE_09: raw event at first valid line start
// RULE_10: first vsync is the frame boundary crossing
// RULE_11: raw capture starts at once on enable
// RULE_12: capture starts and signals at first vsync
// RULE_13: display fetches immediately after enable
// RULE_14: mid-frame enable stores from next frame
// RULE_15: raw line-interval events from channel zero
// RULE_16: suspend input stalls only at frame end
// RULE_17: capture finishes frame then stalls softly
// RULE_18: display repeats frame, withholds events
// RULE_19: suspended writes apply at first vsync after
// RULE_20: host disables ancillary, waits, clears enable
// RULE_21: clearing enable stops channel immediately
// RULE_22: other config latched at vsync falling edge
// RULE_23: events are one-cycle pulses
`timescale 1ns/10ps
`include "vpc_defs.vh"
module vpc_channel_control (
   input wire clk,
   input wire reset,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output wire hresp,
   output reg [31:0] hrdata,
   input wire [3:0] linkClk,
   input wire [3:0] vidVert,
   input wire [3:0] vidHor,
   input wire [3:0] vidBottom,
   input wire suspendIn,
   input wire [3:0] xferIdle,
   input wire [3:0] bufOverflow,
   input wire [1:0] lengthError,
   input wire [1:0] codeError,
   output wire frameEventChZero,
   output wire frameEventChOne,
   output wire frameEventChTwo,
   output wire frameEventChThree,
   output reg errorEvent,
   output wire [3:0] storeEnable,
   output wire [3:0] repeatFrame,
   output wire [8:0] dmaRequestSize
);
   reg [31:0] ctrlQ [0:3];
   reg [31:0] lcfgQ [0:3];
   reg [31:0] emuQ;
   reg [8:0] reqQ;
   reg wrQ;
   reg [7:0] wrAddrQ;
   reg suspS1;
   reg suspS2;
   reg errAnyD;
   wire [3:0] evt;
   wire [3:0] storeQv;
   wire [3:0] stallQv;
   wire [3:0] pendQv;
   wire [15:0] status;
   wire [2:0] cIdx;
   wire suspAct;
   wire errAny;
   integer i;

   // zero-wait slave, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign cIdx = wrAddrQ[4:2] - 3'h1;
   assign suspAct = suspS2 & ~emuQ[`VPC_FREE_BIT];
   assign dmaRequestSize = reqQ;
   assign frameEventChZero = evt[0];
   assign frameEventChOne = evt[1];
   assign frameEventChTwo = evt[2];
   assign frameEventChThree = evt[3];

   // status word: per channel store, stall, pending, armed
   genvar s;
   generate
      for (s = 0; s < 4; s = s + 1) begin : gStat
         assign status[4*s+3:4*s] = {ctrlQ[s][`VPC_EN_BIT] & ~storeQv[s],
            pendQv[s], stallQv[s], storeQv[s]};
      end
   endgenerate

   // address phase captures writes; reads answer in data phase
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         wrQ <= 1'b0;
         wrAddrQ <= 8'h00;
         hrdata <= 32'h00000000;
      end else if (hready) begin
         wrQ <= hsel & htrans[1] & hwrite;
         wrAddrQ <= haddr[7:0];
         hrdata <= 32'h00000000;
         if (hsel & htrans[1] & ~hwrite) begin
            if (haddr[7:0] >= `VPC_CTRL0_OFS && haddr[7:0] <= `VPC_CTRL3_OFS)
               hrdata <= ctrlQ[haddr[3:2] - 2'h1];
            else if (haddr[7:0] >= `VPC_LCFG0_OFS && haddr[7:0] <= `VPC_LCFG3_OFS)
               hrdata <= lcfgQ[haddr[3:2]];
            else if (haddr[7:0] == `VPC_STAT_OFS)
               hrdata <= {16'h0000, status};
            else if (haddr[7:0] == `VPC_EMU_OFS)
               hrdata <= emuQ;
            else if (haddr[7:0] == `VPC_REQ_OFS)
               hrdata <= {23'h000000, reqQ};
         end
      end
   end

   // register file; unmapped writes are dropped
   always @(posedge clk or posedge reset) begin
      if (reset) begin // [RULE_01]
         for (i = 0; i < 4; i = i + 1) begin
            ctrlQ[i] <= `VPC_CTRL_RST;
            lcfgQ[i] <= `VPC_LCFG_RST;
         end
         emuQ <= `VPC_EMU_RST;
         reqQ <= `VPC_REQ_RST;
      end else if (wrQ) begin
         // enable and line interval act at once; other control fields wait for vsync [RULE_21]
         if (wrAddrQ >= `VPC_CTRL0_OFS && wrAddrQ <= `VPC_CTRL3_OFS)
            ctrlQ[cIdx[1:0]] <= hwdata;
         else if (wrAddrQ >= `VPC_LCFG0_OFS && wrAddrQ <= `VPC_LCFG3_OFS)
            lcfgQ[wrAddrQ[3:2]] <= hwdata;
         else if (wrAddrQ == `VPC_EMU_OFS)
            emuQ <= hwdata;
         else if (wrAddrQ == `VPC_REQ_OFS)
            reqQ <= hwdata[`VPC_REQ_MSB:0];
      end
   end

   // suspend comes from the halted processor, resynchronised
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         suspS1 <= 1'b0;
         suspS2 <= 1'b0;
      end else begin
         suspS1 <= suspendIn;
         suspS2 <= suspS1;
      end
   end

   // shared error event: capture has three causes, display one
   assign errAny = (|(lengthError & {ctrlQ[1][0], ctrlQ[0][0]})) // [RULE_04]
      | (|(codeError & {ctrlQ[1][0], ctrlQ[0][0]}))
      | (|(bufOverflow & {ctrlQ[3][0], ctrlQ[2][0], ctrlQ[1][0], ctrlQ[0][0]})); // [RULE_05]

   // one pulse per onset; a held cause is not re-signalled
   always @(posedge clk or posedge reset) begin
      if (reset) begin
         errAnyD <= 1'b0;
         errorEvent <= 1'b0;
      end else begin
         errAnyD <= errAny;
         errorEvent <= errAny & ~errAnyD; // [RULE_03] [RULE_06] [RULE_23]
      end
   end

   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : gCh
         localparam IS_CAP = (g < 2);
         reg [3:0] syncS1;
         reg [3:0] syncS2;
         reg clkD;
         reg vertL;
         reg horL;
         reg botL;
         reg [31:0] wrkCtrlQ;
         reg [31:0] wrkLcfgQ;
         reg enD;
         reg storeQ;
         reg stallQ;
         reg pendQ;
         reg evtQ;
         reg rawSeenQ;
         reg [10:0] lineQ;
         reg [7:0] intvQ;
         wire en;
         wire linkEdge;
         wire vertFall;
         wire horFall;
         wire horRise;
         wire raw;
         wire [7:0] intv;
         wire [10:0] lineN;
         wire ycHit;
         wire rawHit;
         wire lineHit;
         wire cond;

         assign en = ctrlQ[g][`VPC_EN_BIT];
         assign raw = IS_CAP & wrkCtrlQ[`VPC_RAW_BIT];
         // line interval always taken from channel zero
         assign intv = ctrlQ[0][`VPC_INTV_MSB:`VPC_INTV_LSB];
         assign lineN = lineQ + 11'h001;
         // pins sampled only on a rising edge of the link clock
         assign linkEdge = syncS2[3] & ~clkD;
         assign vertFall = linkEdge & vertL & ~syncS2[2];
         assign horFall = linkEdge & horL & ~syncS2[1];
         assign horRise = linkEdge & ~horL & syncS2[1];
         // YC: end of line on first line, or bottom line by field
         assign ycHit = ~raw & horFall & ((lineN == wrkLcfgQ[`VPC_L1_MSB:`VPC_L1_LSB])
            | (wrkCtrlQ[`VPC_FLDINT_BIT] & botL
            & (lineN == wrkLcfgQ[`VPC_L7_MSB:`VPC_L7_LSB]))); // [RULE_08]
         // raw: first line start inside vertical valid area
         assign rawHit = raw & horRise & vertL & ~rawSeenQ; // [RULE_09]
         assign lineHit = raw & horRise & vertL & (intv != 8'h00)
            & (intvQ == intv - 8'h01); // [RULE_15]
         // a stalled channel raises no frame event [RULE_18]
         assign cond = ~stallQ & (storeQ | ~IS_CAP) & (ycHit | rawHit | lineHit);
         assign evt[g] = evtQ;
         assign storeQv[g] = storeQ;
         assign stallQv[g] = stallQ;
         assign pendQv[g] = pendQ;
         assign storeEnable[g] = storeQ & ~(IS_CAP & stallQ);
         assign repeatFrame[g] = ~IS_CAP & stallQ;

         // two flops per pin before any logic looks at it
         always @(posedge clk or posedge reset) begin
            if (reset) begin
               syncS1 <= 4'h0;
               syncS2 <= 4'h0;
               clkD <= 1'b0;
               // idle vertical level is high, so no false fall after reset
               vertL <= 1'b1;
               horL <= 1'b0;
               botL <= 1'b0;
            end else begin
               syncS1 <= {linkClk[g], vidVert[g], vidHor[g], vidBottom[g]};
               syncS2 <= syncS1;
               clkD <= syncS2[3];
               if (linkEdge) begin
                  vertL <= syncS2[2];
                  horL <= syncS2[1];
                  botL <= syncS2[0];
               end
            end
         end

         // channel sequencing
         always @(posedge clk or posedge reset) begin
            if (reset) begin
               wrkCtrlQ <= `VPC_CTRL_RST;
               wrkLcfgQ <= `VPC_LCFG_RST;
               enD <= 1'b0;
               storeQ <= 1'b0;
               stallQ <= 1'b0;
               pendQ <= 1'b0;
               evtQ <= 1'b0;
               rawSeenQ <= 1'b0;
               lineQ <= 11'h000;
               intvQ <= 8'h00;
            end else begin
               enD <= en;
               evtQ <= 1'b0;
               if (!en) begin
                  // no drain: stop on the spot [RULE_21]
                  storeQ <= 1'b0;
                  stallQ <= 1'b0;
                  pendQ <= 1'b0;
                  rawSeenQ <= 1'b0;
               end else begin
                  if (!enD) begin
                     // display fetches now, raw capture too [RULE_13] [RULE_11]
                     storeQ <= ~IS_CAP | ctrlQ[g][`VPC_RAW_BIT];
                     wrkCtrlQ <= ctrlQ[g];
                     wrkLcfgQ <= lcfgQ[g];
                  end
                  if (horFall)
                     lineQ <= lineN;
                  if (horRise & vertL)
                     intvQ <= (intvQ == intv - 8'h01) ? 8'h00 : intvQ + 8'h01;
                  if (rawHit)
                     rawSeenQ <= 1'b1;
                  if (vertFall) begin
                     // the vsync crossing restarts line count [RULE_10]
                     lineQ <= 11'h000;
                     intvQ <= 8'h00;
                     rawSeenQ <= 1'b0;
                     if (suspAct & !stallQ & enD) begin
                        // frame finished, now hold [RULE_16] [RULE_17]
                        stallQ <= 1'b1;
                     end else if (!suspAct) begin
                        // config latch; also resumes a stall [RULE_22] [RULE_19]
                        stallQ <= 1'b0;
                        wrkCtrlQ <= ctrlQ[g];
                        wrkLcfgQ <= lcfgQ[g];
                        if (IS_CAP & !storeQ & enD) begin
                           // first vsync: start and signal [RULE_12] [RULE_14]
                           storeQ <= 1'b1;
                           pendQ <= 1'b1;
                        end
                     end
                  end
                  // event waits for bus drain; new cond beats clear [RULE_07]
                  if (cond)
                     pendQ <= 1'b1;
                  else if (pendQ & xferIdle[g] & !(vertFall & IS_CAP & !storeQ))
                     pendQ <= 1'b0;
                  if (pendQ & xferIdle[g] & !stallQ)
                     evtQ <= 1'b1; // [RULE_03] [RULE_06] [RULE_23]
               end
            end
         end
      end
   endgenerate
endmodule

// file: vpc_channel_control_tb_top.sv
// self-checking bench for the channel control block
// assumes a zero-wait bus slave and one video source on all channels
`timescale 1ns/10ps
`include "vpc_defs.vh"
module vpc_channel_control_tb_top;
   reg clk = 1'b0;
   reg reset = 1'b1;
   reg hsel = 1'b0;
   reg [31:0] haddr = 32'h00000000;
   reg [1:0] htrans = 2'h0;
   reg hwrite = 1'b0;
   reg [31:0] hwdata = 32'h00000000;
   reg suspendIn = 1'b0;
   reg [3:0] xferIdle = 4'hF;
   reg [3:0] vidBottom = 4'h0;
   reg [7:0] errCause = 8'h00;
   reg [31:0] rd;
   wire hreadyout, hresp, linkClk, vidVert, vidHor, ev0, ev1, ev2, ev3, errorEvent;
   wire [31:0] hrdata;
   wire [3:0] storeEnable, repeatFrame;
   wire [8:0] dmaRequestSize;
   integer n_fail = 0, check_count = 0, ev0Cnt = 0, errCnt = 0, i;
   localparam logic [7:0] OFS [7] = '{8'h04, 8'h10, 8'h2C, 8'h34, 8'h38, 8'h40, 8'h00};
   always #25 clk = ~clk;
   vpc_video_src u_vpc_video_src (.linkClk(linkClk), .vidVert(vidVert), .vidHor(vidHor));
   vpc_channel_control u_vpc_channel_control (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .linkClk({4{linkClk}}), .vidVert({4{vidVert}}),
      .vidHor({4{vidHor}}), .vidBottom(vidBottom), .suspendIn(suspendIn), .xferIdle(xferIdle),
      .bufOverflow(errCause[3:0]), .lengthError(errCause[5:4]), .codeError(errCause[7:6]),
      .frameEventChZero(ev0), .frameEventChOne(ev1), .frameEventChTwo(ev2), .frameEventChThree(ev3),
      .errorEvent(errorEvent), .storeEnable(storeEnable), .repeatFrame(repeatFrame),
      .dmaRequestSize(dmaRequestSize));
   // count pulses; an unknown never counts
   always @(posedge clk) begin
      ev0Cnt <= ev0Cnt + (ev0 === 1'b1);
      errCnt <= errCnt + (errorEvent === 1'b1);
   end
   task check(input [31:0] seen, input [31:0] exp);
      begin
         check_count = check_count + 1;
         if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   task print_verdict;
      begin
         $display("checks=%0d fails=%0d", check_count, n_fail);
         if (n_fail == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask
   // next edge with ready high; a stuck bus ends the run
   task waitRdy;
      integer k;
      begin
         k = 0;
         @(posedge clk);
         while (hreadyout !== 1'b1 && k < 20) begin
            @(posedge clk);
            k = k + 1;
         end
         if (k == 20) begin
            n_fail = n_fail + 1;
            print_verdict;
         end
      end
   endtask
   // single word transfer; read data taken at the data phase edge
   task xfer(input wr, input [7:0] a, input [31:0] d);
      begin
         @(posedge clk);
         hsel <= 1'b1;
         haddr <= {24'h000000, a};
         htrans <= 2'h2;
         hwrite <= wr;
         waitRdy;
         htrans <= 2'h0;
         hwdata <= d;
         waitRdy;
         rd = hrdata;
      end
   endtask
   // let a written register reach the outputs
   task settle;
      begin
         repeat (2) @(posedge clk);
         #1;
      end
   endtask
   initial begin
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      for (i = 0; i < 7; i = i + 1) begin
         xfer(1'b0, OFS[i], 32'h00000000);
         check(rd, 32'h00000000);
      end
      // host setup order: request size, then emulation
      xfer(1'b1, `VPC_REQ_OFS, 32'h000001FF);
      xfer(1'b1, `VPC_EMU_OFS, 32'h00000000);
      xfer(1'b1, 8'h00, 32'hFFFFFFFF);
      xfer(1'b0, `VPC_REQ_OFS, 32'h00000000);
      check(rd, 32'h000001FF);
      check(dmaRequestSize, 9'h1FF);
      xfer(1'b0, 8'h00, 32'h00000000);
      check(rd, 32'h00000000);
      // yc capture: armed until the first vertical fall
      xfer(1'b1, `VPC_LCFG0_OFS, 32'h00000002);
      xfer(1'b1, `VPC_CTRL0_OFS, 32'h00000001);
      settle;
      check(storeEnable[0], 1'b0);
      u_vpc_video_src.frame(4);
      settle;
      check(ev0Cnt, 2);
      check(storeEnable[0], 1'b1);
      // outstanding transfer holds the event back
      xferIdle <= 4'hE;
      u_vpc_video_src.frame(4);
      settle;
      check(ev0Cnt, 2);
      xferIdle <= 4'hF;
      settle;
      check(ev0Cnt, 3);
      u_vpc_video_src.frame(4);
      settle;
      check(ev0Cnt, 4);
      // field events: bottom line 3 adds a second event per frame
      xfer(1'b1, `VPC_LCFG0_OFS, 32'h00030002);
      xfer(1'b1, `VPC_CTRL0_OFS, 32'h00000003);
      vidBottom <= 4'hF;
      u_vpc_video_src.frame(4);
      settle;
      check(ev0Cnt, 6);
      vidBottom <= 4'h0;
      xfer(1'b1, `VPC_CTRL0_OFS, 32'h00000000);
      settle;
      check(storeEnable[0], 1'b0);
      xfer(1'b1, `VPC_CTRL0_OFS, 32'h00000009);
      settle;
      check(storeEnable[0], 1'b1);
      // display fetches at once, then stalls under suspend
      xfer(1'b1, 8'h0C, 32'h00000001);
      settle;
      check(storeEnable[2], 1'b1);
      @(posedge clk);
      suspendIn <= 1'b1;
      u_vpc_video_src.frame(4);
      settle;
      check(repeatFrame[2], 1'b1);
      suspendIn <= 1'b0;
      u_vpc_video_src.frame(4);
      settle;
      check(repeatFrame[2], 1'b0);
      // one pulse per cause: overflow 0, overflow 2, length 0, code 0
      for (i = 0; i < 8; i = i + 2) begin
         @(posedge clk);
         errCause <= 8'h01 << i;
         @(posedge clk);
         errCause <= 8'h00;
         settle;
         check(errCnt, i / 2 + 1);
      end
      print_verdict;
   end
endmodule

// file: vpc_checker_assertions.sv
// timing checks on the channel control outputs
// assumes one clock domain and an active high reset
`timescale 1ns/10ps
module vpc_checker (
   input wire clk,
   input wire reset,
   input wire [3:0] xferIdle,
   input wire [3:0] bufOverflow,
   input wire [1:0] lengthError,
   input wire [1:0] codeError,
   input wire frameEventChZero,
   input wire frameEventChTwo,
   input wire errorEvent,
   input wire [3:0] storeEnable,
   input wire [3:0] repeatFrame
);
   default clocking dc @(posedge clk); endclocking
   default disable iff (reset);
   AST_RESET_IDLE: assert property ($fell(reset) |-> storeEnable == 4'h0 && repeatFrame == 4'h0)
      else $error("channel active right after reset");
   AST_EV0_PULSE: assert property (frameEventChZero |=> !frameEventChZero)
      else $error("channel zero event longer than one cycle");
   AST_EV2_PULSE: assert property (frameEventChTwo |=> !frameEventChTwo)
      else $error("channel two event repeated");
   AST_ERR_PULSE: assert property (errorEvent |=> !errorEvent)
      else $error("error event longer than one cycle");
   AST_EV0_AFTER_IDLE: assert property (frameEventChZero |-> $past(xferIdle[0]))
      else $error("frame event while transfer outstanding");
   AST_ERR_CAUSE: assert property (errorEvent |-> $past(|{bufOverflow, lengthError, codeError}))
      else $error("error event without a cause");
   AST_CAPTURE_NO_REPEAT: assert property (repeatFrame[1:0] == 2'b00)
      else $error("capture channel repeating a frame");
   AST_STALL_QUIET: assert property (repeatFrame[2] |-> !frameEventChTwo)
      else $error("stalled display raised an event");
endmodule
bind vpc_channel_control vpc_checker u_vpc_checker (.clk, .reset, .xferIdle, .bufOverflow, .lengthError,
   .codeError, .frameEventChZero, .frameEventChTwo, .errorEvent, .storeEnable, .repeatFrame);

// file: vpc_defs.vh
// constants for the video port channel control block
// assumes one AHB-Lite slave port, 32-bit words, byte addresses
`ifndef VPC_DEFS_VH
`define VPC_DEFS_VH
// register byte offsets
`define VPC_CTRL0_OFS 8'h04
`define VPC_CTRL3_OFS 8'h10
`define VPC_STAT_OFS 8'h2C
`define VPC_EMU_OFS 8'h34
`define VPC_REQ_OFS 8'h38
`define VPC_LCFG0_OFS 8'h40
`define VPC_LCFG3_OFS 8'h4C
// channel control fields
`define VPC_EN_BIT 0
`define VPC_FLDINT_BIT 1
`define VPC_RAW_BIT 3
`define VPC_HANC_BIT 4
`define VPC_VANC_BIT 5
`define VPC_INTV_LSB 8
`define VPC_INTV_MSB 15
// line config fields
`define VPC_L1_LSB 0
`define VPC_L1_MSB 10
`define VPC_L7_LSB 16
`define VPC_L7_MSB 26
// emulation control: ignore suspend
`define VPC_FREE_BIT 0
`define VPC_REQ_MSB 8
// reset values
`define VPC_CTRL_RST 32'h00000000
`define VPC_LCFG_RST 32'h00000000
`define VPC_EMU_RST 32'h00000000
`define VPC_REQ_RST 9'h000
`endif

// file: vpc_video_src.sv
// video source model: sync levels on a gated pixel clock
// assumes the port samples pins on the rising link clock
`timescale 1ns/10ps
module vpc_video_src (
   output reg linkClk,
   output reg vidVert,
   output reg vidHor
);
   // idle: clock still, blanking levels
   initial begin
      linkClk = 1'b0;
      vidVert = 1'b1;
      vidHor = 1'b0;
   end
   // pins only move in the low phase, so no sample sees a change
   task tick;
      begin
         #200 linkClk = 1'b1;
         #200 linkClk = 1'b0;
      end
   endtask
   // vertical fall, then n lines each ending on a horizontal fall
   task frame(input integer n);
      integer i;
      begin
         vidVert = 1'b0; // frame boundary
         tick;
         for (i = 0; i < n; i = i + 1) begin
            vidHor = 1'b1;
            tick;
            tick;
            vidHor = 1'b0; // end of active line
            tick;
            tick;
         end
         vidVert = 1'b1;
         tick;
         tick;
      end
   endtask
endmodule
